/* File: codec_volume_jack_adc_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none

module codec_volume_jack_adc_ctrl_test;
  logic mclk;
  logic rst;
  cvj_pkg::cvj_bus_t bus;
  logic [8:0] rdata;
  logic frameStrobe;
  logic jackDetectEnable;
  logic jackLevel;
  cvj_pkg::cvj_drivers_t drivers;
  cvj_pkg::cvj_hpf_t highpass_cutoff_select;
  logic [3:0][7:0] liveGain;
  logic playbackLeftMute;
  logic playbackRightMute;
  logic [7:0] playbackLeftAtten;
  logic [7:0] playbackRightAtten;
  logic recordStrobe;
  logic [23:0] recordLeftIn;
  logic [23:0] recordRightIn;
  logic [23:0] recordLeftOut;
  logic [23:0] recordRightOut;
  logic recordValid;
  logic [8:0] rval;
  int errCount;
  int compares;

  cvj_config_regs i_cvj_config_regs (
    .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .frameStrobe(frameStrobe),
    .jackDetectEnable(jackDetectEnable), .jackLevel(jackLevel), .drivers(drivers),
    .highpass_cutoff_select(highpass_cutoff_select), .liveGain(liveGain), .playbackLeftMute(playbackLeftMute),
    .playbackRightMute(playbackRightMute), .playbackLeftAtten(playbackLeftAtten),
    .playbackRightAtten(playbackRightAtten), .recordStrobe(recordStrobe),
    .recordLeftIn(recordLeftIn), .recordRightIn(recordRightIn),
    .recordLeftOut(recordLeftOut), .recordRightOut(recordRightOut),
    .recordValid(recordValid)
  );

  always #5 mclk = ~mclk;

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    rval = rdata;
  endtask

  task automatic frame;
    @(posedge mclk);
    frameStrobe <= 1'b1;
    @(posedge mclk);
    frameStrobe <= 1'b0;
    #1;
  endtask

  task automatic jack(input logic en, input logic lvl);
    @(posedge mclk);
    jackDetectEnable <= en;
    jackLevel <= lvl;
    @(posedge mclk);
    #1;
  endtask

  task automatic rec(input logic [23:0] l, input logic [23:0] r);
    @(posedge mclk);
    recordStrobe <= 1'b1;
    recordLeftIn <= l;
    recordRightIn <= r;
    @(posedge mclk);
    recordStrobe <= 1'b0;
    #1;
  endtask

  task automatic test_reset;
    rd(7'h0C);
    check(32'(rval), 32'h0FF);
    rd(7'h0D);
    check(32'(rval), 32'h000);
    rd(7'h0E);
    check(32'(rval), 32'h100);
    check(32'(highpass_cutoff_select), 32'h20);
    check(32'(liveGain), 32'hFFFFFFFF);
    rd(7'h20);
    check(32'(rval), 32'h000);
    $display("test reset done");
  endtask

  task automatic test_playback;
    logic [7:0] codes [3];
    logic [8:0] exps [3];
    codes = '{8'h00, 8'h01, 8'hFF};
    exps = '{9'h1FF, 9'h0FE, 9'h000};
    wr(7'h0B, 9'h040);
    wr(7'h0C, 9'h020);
    frame();
    check(32'(liveGain[1:0]), 32'hFFFF);
    rd(7'h0C);
    check(32'(rval), 32'h020);
    wr(7'h0C, 9'h180);
    check(32'(liveGain[1:0]), 32'hFFFF);
    frame();
    check(32'(liveGain[1:0]), 32'h8040);
    check(32'({playbackLeftMute, playbackLeftAtten}), 32'h0BF);
    rd(7'h0C);
    check(32'(rval), 32'h080);
    for (int i = 0; i < 3; i++) begin
      wr(7'h0C, {1'b1, codes[i]});
      frame();
      check(32'({playbackRightMute, playbackRightAtten}), 32'(exps[i]));
    end
    wr(7'h0B, 9'h000);
    wr(7'h0C, 9'h1FF);
    frame();
    check(32'({playbackLeftMute, playbackLeftAtten}), 32'h1FF);
    wr(7'h0B, 9'h101);
    frame();
    check(32'({playbackLeftMute, playbackLeftAtten}), 32'h0FE);
    check(32'(liveGain[1:0]), 32'hFF01);
    $display("test playback done");
  endtask

  task automatic test_record_gain;
    wr(7'h10, 9'h033);
    wr(7'h0F, 9'h011);
    frame();
    check(32'(liveGain[3:2]), 32'hFFFF);
    wr(7'h0F, 9'h122);
    frame();
    check(32'(liveGain[3:2]), 32'h3322);
    rd(7'h0F);
    check(32'(rval), 32'h022);
    wr(7'h10, 9'h144);
    frame();
    check(32'(liveGain[3:2]), 32'h4422);
    $display("test record gain done");
  endtask

  task automatic test_jack;
    logic [7:0] maps [2];
    maps = '{8'hA5, 8'h5A};
    for (int i = 0; i < 2; i++) begin
      wr(7'h0D, {1'b1, maps[i]});
      rd(7'h0D);
      check(32'(rval), 32'({1'b0, maps[i]}));
      jack(1'b1, 1'b1);
      check(32'(drivers), 32'(maps[i][7:4]));
      jack(1'b1, 1'b0);
      check(32'(drivers), 32'(maps[i][3:0]));
      jack(1'b0, 1'b1);
      check(32'(drivers), 32'h0);
    end
    $display("test jack done");
  endtask

  task automatic test_adc;
    wr(7'h0E, 9'h1FF);
    rd(7'h0E);
    check(32'(rval), 32'h1FB);
    check(32'(highpass_cutoff_select), 32'h3F);
    rec(24'h000010, 24'h800000);
    check(32'(recordValid), 32'h1);
    check(32'(recordLeftOut), 32'hFFFFF0);
    check(32'(recordRightOut), 32'h7FFFFF);
    @(posedge mclk);
    #1;
    check(32'(recordValid), 32'h0);
    wr(7'h0E, 9'h1D2);
    rec(24'h000010, 24'h000010);
    check(32'(highpass_cutoff_select), 32'h3A);
    check(32'(recordLeftOut), 32'h000010);
    check(32'(recordRightOut), 32'hFFFFF0);
    wr(7'h0E, 9'h000);
    rd(7'h0E);
    check(32'(highpass_cutoff_select), 32'h00);
    wr(7'h0E, 9'h100);
    rd(7'h0E);
    check(32'(highpass_cutoff_select), 32'h20);
    $display("test adc done");
  endtask

  task automatic test_mid_reset;
    wr(7'h0E, 9'h08A);
    rd(7'h0E);
    check(32'(rval), 32'h08A);
    check(32'(highpass_cutoff_select), 32'h11);
    jack(1'b1, 1'b1);
    rec(24'h000010, 24'h000020);
    check(32'(recordRightOut), 32'hFFFFE0);
    @(posedge mclk);
    rst <= 1'b1;
    #1;
    check(32'(liveGain), 32'hFFFFFFFF);
    check(32'(highpass_cutoff_select), 32'h20);
    check(32'({drivers, recordValid}), 32'h0);
    check(32'(recordRightOut), 32'h0);
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(7'h0C);
    check(32'(rval), 32'h0FF);
    check(32'(drivers), 32'h0);
    $display("test mid reset done");
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    bus = '0;
    frameStrobe = 1'b0;
    jackDetectEnable = 1'b0;
    jackLevel = 1'b0;
    recordStrobe = 1'b0;
    recordLeftIn = '0;
    recordRightIn = '0;
    errCount = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_playback();
    test_record_gain();
    test_jack();
    test_adc();
    test_mid_reset();
    close_out();
  end

  // tests need well under 1000 cycles
  initial begin
    #50000;
    errCount++;
    close_out();
  end
endmodule // codec_volume_jack_adc_ctrl_test

`default_nettype wire

/* File: cvj_config_regs.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module cvj_config_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire cvj_pkg::cvj_bus_t bus,
  output logic [8:0] rdata,
  input wire logic frameStrobe,
  input wire logic jackDetectEnable,
  input wire logic jackLevel,
  output cvj_pkg::cvj_drivers_t drivers,
  output cvj_pkg::cvj_hpf_t highpass_cutoff_select,
  output logic [3:0][7:0] liveGain,
  output logic playbackLeftMute,
  output logic playbackRightMute,
  output logic [7:0] playbackLeftAtten,
  output logic [7:0] playbackRightAtten,
  input wire logic recordStrobe,
  input wire logic [cvj_pkg::CVJ_SAMPLE_W-1:0] recordLeftIn,
  input wire logic [cvj_pkg::CVJ_SAMPLE_W-1:0] recordRightIn,
  output logic [cvj_pkg::CVJ_SAMPLE_W-1:0] recordLeftOut,
  output logic [cvj_pkg::CVJ_SAMPLE_W-1:0] recordRightOut,
  output logic recordValid
);

  typedef struct packed {
    cvj_pkg::cvj_vol_t [3:0] vol;
    logic [7:0] jackMap;
    logic [8:0] adcCtrl;
    logic [8:0] rdata;
    cvj_pkg::cvj_drivers_t drivers;
  } cvj_state_t;

  cvj_state_t q;
  cvj_state_t next_q;

  function automatic logic [6:0] cvj_vol_addr(input int slot);
    case (slot)
      cvj_pkg::CVJ_VOL_DAC_L: cvj_vol_addr = cvj_pkg::CVJ_ADDR_LDAC_VOL;
      cvj_pkg::CVJ_VOL_DAC_R: cvj_vol_addr = cvj_pkg::CVJ_ADDR_RDAC_VOL;
      cvj_pkg::CVJ_VOL_ADC_L: cvj_vol_addr = cvj_pkg::CVJ_ADDR_LADC_VOL;
      default: cvj_vol_addr = cvj_pkg::CVJ_ADDR_RADC_VOL;
    endcase
  endfunction

  always_comb begin
    next_q = q;
    next_q.rdata = '0;

    // active gains reach the audio path only at a frame boundary, all at once
    if (frameStrobe) begin
      for (int i = 0; i < 4; i++) begin
        next_q.vol[i].live = q.vol[i].act;
      end
    end

    if (bus.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (bus.addr == cvj_vol_addr(i)) begin
          next_q.vol[i].pend = bus.wdata[7:0];
          if (bus.wdata[cvj_pkg::CVJ_BIT_COMMIT]) begin
            next_q.vol[i].act = bus.wdata[7:0];
            next_q.vol[i ^ 1].act = q.vol[i ^ 1].pend;
          end
        end
      end
      if (bus.addr == cvj_pkg::CVJ_ADDR_JACK_MAP) begin
        next_q.jackMap = bus.wdata[7:0];
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL) begin
        next_q.adcCtrl = bus.wdata & cvj_pkg::CVJ_ADC_CTRL_MASK;
      end
    end

    if (bus.rd) begin
      if (bus.addr == cvj_pkg::CVJ_ADDR_LDAC_VOL) begin
        next_q.rdata = {1'b0, q.vol[cvj_pkg::CVJ_VOL_DAC_L].pend};
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_RDAC_VOL) begin
        next_q.rdata = {1'b0, q.vol[cvj_pkg::CVJ_VOL_DAC_R].pend};
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_LADC_VOL) begin
        next_q.rdata = {1'b0, q.vol[cvj_pkg::CVJ_VOL_ADC_L].pend};
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_RADC_VOL) begin
        next_q.rdata = {1'b0, q.vol[cvj_pkg::CVJ_VOL_ADC_R].pend};
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_JACK_MAP) begin
        next_q.rdata = {1'b0, q.jackMap};
      end else if (bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL) begin
        next_q.rdata = q.adcCtrl;
      end
    end

    // driver enables follow the jack level each cycle; nothing on while detection is off
    if (!jackDetectEnable) begin
      next_q.drivers = '0;
    end else if (jackLevel) begin
      next_q.drivers = q.jackMap[cvj_pkg::CVJ_JACK_HIGH_LSB +: 4];
    end else begin
      next_q.drivers = q.jackMap[3:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        q.vol[i] <= {3{cvj_pkg::CVJ_RST_GAIN}};
      end
      q.jackMap <= cvj_pkg::CVJ_RST_JACK_MAP;
      q.adcCtrl <= cvj_pkg::CVJ_RST_ADC_CTRL;
      q.rdata <= '0;
      q.drivers <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign drivers = q.drivers;

  // filter steering straight from the control flops
  assign highpass_cutoff_select.enable = q.adcCtrl[cvj_pkg::CVJ_BIT_HP_EN];
  assign highpass_cutoff_select.mode = q.adcCtrl[cvj_pkg::CVJ_BIT_HP_MODE];
  assign highpass_cutoff_select.cutoff = q.adcCtrl[cvj_pkg::CVJ_BIT_CUTOFF +: 3];
  assign highpass_cutoff_select.oversample = q.adcCtrl[cvj_pkg::CVJ_BIT_OSR];

  for (genvar g = 0; g < 4; g++) begin : g_live
    assign liveGain[g] = q.vol[g].live;
  end

  assign playbackLeftMute = q.vol[cvj_pkg::CVJ_VOL_DAC_L].live == cvj_pkg::CVJ_GAIN_MUTE;
  assign playbackRightMute = q.vol[cvj_pkg::CVJ_VOL_DAC_R].live == cvj_pkg::CVJ_GAIN_MUTE;
  assign playbackLeftAtten = cvj_pkg::cvj_atten(q.vol[cvj_pkg::CVJ_VOL_DAC_L].live);
  assign playbackRightAtten = cvj_pkg::cvj_atten(q.vol[cvj_pkg::CVJ_VOL_DAC_R].live);

  logic [1:0] chanInvert;
  logic [1:0][cvj_pkg::CVJ_SAMPLE_W-1:0] chanIn;
  logic [1:0][cvj_pkg::CVJ_SAMPLE_W-1:0] chanOut;
  logic [1:0] chanValid;

  assign chanInvert = {q.adcCtrl[cvj_pkg::CVJ_BIT_RINV], q.adcCtrl[cvj_pkg::CVJ_BIT_LINV]};
  assign chanIn = {recordRightIn, recordLeftIn};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    cvj_record_channel i_cvj_record_channel (
      .mclk(mclk),
      .rst(rst),
      .strobe(recordStrobe),
      .invert(chanInvert[c]),
      .sampleIn(chanIn[c]),
      .sampleOut(chanOut[c]),
      .sampleValid(chanValid[c])
    );
  end

  assign recordLeftOut = chanOut[0];
  assign recordRightOut = chanOut[1];
  // both channels share the strobe, so their valid flags always agree
  assign recordValid = &chanValid;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_rdac_commit;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_RDAC_VOL && bus.wdata[8]
      |=> q.vol[1].act == $past(bus.wdata[7:0]) && q.vol[0].act == $past(q.vol[0].pend);
  endproperty
  a_rdac_commit: assert property (p_rdac_commit) else $error("right playback commit wrong");

  property p_rdac_hold;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_RDAC_VOL && !bus.wdata[8]
      |=> $stable(q.vol[1].act) && q.vol[1].pend == $past(bus.wdata[7:0]);
  endproperty
  a_rdac_hold: assert property (p_rdac_hold) else $error("right playback applied early");

  property p_mute;
    playbackRightMute |-> playbackRightAtten == 8'hFF && liveGain[1] == 8'h00;
  endproperty
  a_mute: assert property (p_mute) else $error("mute decode wrong");

  property p_jack_high;
    jackDetectEnable && jackLevel |=> drivers == $past(q.jackMap[7:4]);
  endproperty
  a_jack_high: assert property (p_jack_high) else $error("high jack map wrong");

  property p_jack_low;
    jackDetectEnable && !jackLevel |=> drivers == $past(q.jackMap[3:0]);
  endproperty
  a_jack_low: assert property (p_jack_low) else $error("low jack map wrong");

  property p_ctrl_write;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL |=> highpass_cutoff_select.enable == $past(bus.wdata[8])
      && highpass_cutoff_select.mode == $past(bus.wdata[7]) && highpass_cutoff_select.oversample == $past(bus.wdata[3]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("filter control wrong");

  property p_ladc_hold;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_LADC_VOL && !bus.wdata[8] |=> $stable(q.vol[2].act);
  endproperty
  a_ladc_hold: assert property (p_ladc_hold) else $error("left record applied early");

  property p_ladc_commit;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_LADC_VOL && bus.wdata[8]
      |=> q.vol[2].act == $past(bus.wdata[7:0]) && q.vol[3].act == $past(q.vol[3].pend);
  endproperty
  a_ladc_commit: assert property (p_ladc_commit) else $error("left record commit wrong");

  property p_pair_live;
    frameStrobe |=> liveGain[0] == $past(q.vol[0].act) && liveGain[1] == $past(q.vol[1].act);
  endproperty
  a_pair_live: assert property (p_pair_live) else $error("gains not applied together");

  property p_read_zero;
    bus.rd && bus.addr != cvj_pkg::CVJ_ADDR_ADC_CTRL |=> rdata[8] == 1'b0 ##1 rdata == 9'h000 || $past(bus.rd);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("commit bit read as one");

  property p_jack_off;
    !jackDetectEnable |=> drivers == 4'h0;
  endproperty
  a_jack_off: assert property (p_jack_off) else $error("drivers on while detection off");

  property p_cutoff;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL |=> highpass_cutoff_select.cutoff == $past(bus.wdata[6:4]);
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("cutoff select wrong");

  property p_oversample;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL
      |=> highpass_cutoff_select.oversample == $past(bus.wdata[3]) && highpass_cutoff_select.mode == $past(bus.wdata[7]);
  endproperty
  a_oversample: assert property (p_oversample) else $error("oversample select wrong");

  property p_invert_bits;
    bus.wr && bus.addr == cvj_pkg::CVJ_ADDR_ADC_CTRL |=> chanInvert == $past(bus.wdata[1:0]);
  endproperty
  a_invert_bits: assert property (p_invert_bits) else $error("invert steering wrong");

  property p_read_pend;
    bus.rd && bus.addr == cvj_pkg::CVJ_ADDR_RDAC_VOL
      |=> rdata == {1'b0, $past(q.vol[cvj_pkg::CVJ_VOL_DAC_R].pend)};
  endproperty
  a_read_pend: assert property (p_read_pend) else $error("pending gain read wrong");

endmodule // cvj_config_regs

`default_nettype wire

/* File: cvj_pkg.sv */
package cvj_pkg;

  // register addresses on the control port
  localparam logic [6:0] CVJ_ADDR_LDAC_VOL = 7'h0B;
  localparam logic [6:0] CVJ_ADDR_RDAC_VOL = 7'h0C;
  localparam logic [6:0] CVJ_ADDR_JACK_MAP = 7'h0D;
  localparam logic [6:0] CVJ_ADDR_ADC_CTRL = 7'h0E;
  localparam logic [6:0] CVJ_ADDR_LADC_VOL = 7'h0F;
  localparam logic [6:0] CVJ_ADDR_RADC_VOL = 7'h10;

  // values after reset
  localparam logic [7:0] CVJ_RST_GAIN = 8'hFF;
  localparam logic [7:0] CVJ_RST_JACK_MAP = 8'h00;
  localparam logic [8:0] CVJ_RST_ADC_CTRL = 9'h100;

  // field positions
  localparam int CVJ_BIT_COMMIT = 8;
  localparam int CVJ_BIT_HP_EN = 8;
  localparam int CVJ_BIT_HP_MODE = 7;
  localparam int CVJ_BIT_CUTOFF = 4;
  localparam int CVJ_BIT_OSR = 3;
  localparam int CVJ_BIT_RINV = 1;
  localparam int CVJ_BIT_LINV = 0;
  localparam int CVJ_JACK_HIGH_LSB = 4;
  localparam logic [8:0] CVJ_ADC_CTRL_MASK = 9'h1FB;

  // gain codes and volume channel slots; partner of slot i is i^1
  localparam logic [7:0] CVJ_GAIN_MUTE = 8'h00;
  localparam logic [7:0] CVJ_GAIN_FULL = 8'hFF;
  localparam int CVJ_VOL_DAC_L = 0;
  localparam int CVJ_VOL_DAC_R = 1;
  localparam int CVJ_VOL_ADC_L = 2;
  localparam int CVJ_VOL_ADC_R = 3;
  localparam int CVJ_SAMPLE_W = 24;

  typedef struct packed {
    logic [6:0] addr;
    logic [8:0] wdata;
    logic wr;
    logic rd;
  } cvj_bus_t;

  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] act;
    logic [7:0] live;
  } cvj_vol_t;

  typedef struct packed {
    logic auxOne;
    logic auxTwo;
    logic speaker;
    logic headphone;
  } cvj_drivers_t;

  typedef struct packed {
    logic enable;
    logic mode;
    logic [2:0] cutoff;
    logic oversample;
  } cvj_hpf_t;

  // attenuation in half-dB steps below 0dB; mute code reports full scale
  function automatic logic [7:0] cvj_atten(input logic [7:0] gain);
    cvj_atten = CVJ_GAIN_FULL - gain;
  endfunction

endpackage

/* File: cvj_record_channel.sv */
`timescale 1ns/10ps
`default_nettype none

module cvj_record_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic invert,
  input wire logic [cvj_pkg::CVJ_SAMPLE_W-1:0] sampleIn,
  output logic [cvj_pkg::CVJ_SAMPLE_W-1:0] sampleOut,
  output logic sampleValid
);

  typedef struct packed {
    logic [cvj_pkg::CVJ_SAMPLE_W-1:0] data;
    logic valid;
  } cvj_chan_state_t;

  localparam logic [cvj_pkg::CVJ_SAMPLE_W-1:0] MOST_NEG = {1'b1, {(cvj_pkg::CVJ_SAMPLE_W-1){1'b0}}};

  cvj_chan_state_t q;
  cvj_chan_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.valid = strobe;
    if (strobe) begin
      // negating full-scale negative would wrap, so clamp to positive full scale
      if (!invert) begin
        next_q.data = sampleIn;
      end else if (sampleIn == MOST_NEG) begin
        next_q.data = ~MOST_NEG;
      end else begin
        next_q.data = -sampleIn;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sampleOut = q.data;
  assign sampleValid = q.valid;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_invert;
    strobe && invert && sampleIn != MOST_NEG |=> sampleOut == -$past(sampleIn) && sampleValid;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted sample wrong");

  property p_pass;
    strobe && !invert |=> sampleOut == $past(sampleIn) ##1 sampleOut == $past(sampleIn, 2) || $past(strobe);
  endproperty
  a_pass: assert property (p_pass) else $error("plain sample wrong");

endmodule // cvj_record_channel

`default_nettype wire
